// ==== pkg/ubf_pkg.sv ====
/*
 ubf_pkg: constants shared by the serial port baud generator and framer.
 assumes: one system clock; every control bit arrives as a plain synchronous input.
*/
package ubf_pkg;
   localparam int unsigned   SYS_CLK_HZ     = 125000000;
   localparam int unsigned   DIV_W          = 8;
   localparam int unsigned   FRAME_W        = 12;
   localparam int unsigned   RX_SH_W        = 11;
   // ticks per bit, minus one, for each speed
   localparam logic [5:0]    TPB_SLOW_M1    = 6'h3F;
   localparam logic [5:0]    TPB_FAST_M1    = 6'h0F;
   // mid-bit sampling point in ticks
   localparam logic [5:0]    MID_SLOW       = 6'h1F;
   localparam logic [5:0]    MID_FAST       = 6'h07;
   // values after reset: 8 data bits, no parity, one stop
   localparam logic          NINE_RST       = 1'b0;
   localparam logic          PTYPE_RST      = 1'b0;
   localparam logic          PEN_RST        = 1'b0;
   localparam logic          TWO_RST        = 1'b0;
   localparam logic          HS_RST         = 1'b0;
   localparam logic [7:0]    DIV_RST        = 8'h00;
   localparam logic [11:0]   FRAME_IDLE     = 12'hFFF;
   localparam logic [10:0]   RX_SH_RST      = 11'h000;
   localparam logic [3:0]    POS_RST        = 4'h0;
   localparam logic [5:0]    PH_RST         = 6'h00;
   typedef enum logic [0:0] {TX_IDLE, TX_SEND} ubf_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_DONE} ubf_rx_e;
endpackage

// ==== rtl/ubf_uart.sv ====
/*
 ubf_uart: baud rate generator plus transmit and receive framing of the serial port.
 assumes: inputs synchronous to clk; tx_data/tx_ninth_bit held while tx_valid is high.
*/
`timescale 1ns/1ps
module ubf_uart (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [7:0]   baud_divisor,
   input  wire logic         high_speed_select,
   input  wire logic         nine_bit_select,
   input  wire logic         parity_type,
   input  wire logic         parity_enable,
   input  wire logic         two_stop_select,
   input  wire logic         tx_ninth_bit,
   input  wire logic         uart_enable,
   input  wire logic         tx_enable,
   input  wire logic         rx_enable,
   input  wire logic [7:0]   tx_data,
   input  wire logic         tx_valid,
   output logic              tx_ready,
   output logic              tx_line,
   output logic              tx_line_oe,
   output logic              tx_busy,
   input  wire logic         rx_line,
   output logic [8:0]        rx_data,
   output logic              rx_valid,
   output logic              rx_parity_err,
   output logic              rx_frame_err
);
   // configuration, shared by both directions
   logic          nine_q, nine_d, ptype_q, ptype_d, pen_q, pen_d, two_q, two_d, hs_q, hs_d;
   logic [7:0]    div_q, div_d;
   logic [7:0]    pre_q, pre_d;
   logic          tick;
   logic [5:0]    tpb_m1, mid;
   logic          tx_on, rx_on;
   // transmitter
   ubf_pkg::ubf_tx_e tx_st_q, tx_st_d;
   logic [11:0]   tx_sh_q, tx_sh_d;
   logic [3:0]    tx_pos_q, tx_pos_d, tx_len_q, tx_len_d;
   logic [5:0]    tx_ph_q, tx_ph_d;
   logic          tx_first_q, tx_first_d, tx_par_q, tx_par_d;
   logic          tx_start, tx_bit_end;
   logic [8:0]    tx_word;
   logic [3:0]    nd;
   // receiver
   ubf_pkg::ubf_rx_e rx_st_q, rx_st_d;
   logic [10:0]   rx_sh_q, rx_sh_d;
   logic [3:0]    rx_idx_q, rx_idx_d;
   logic [5:0]    rx_ph_q, rx_ph_d;
   logic          rx_prev_q, rx_prev_d;
   logic [8:0]    rx_data_q, rx_data_d;
   logic          rx_valid_q, rx_valid_d, rx_perr_q, rx_perr_d, rx_ferr_q, rx_ferr_d;

   assign tx_on      = uart_enable & tx_enable;
   assign rx_on      = uart_enable & rx_enable;
   assign tpb_m1     = hs_q ? ubf_pkg::TPB_FAST_M1 : ubf_pkg::TPB_SLOW_M1;
   assign mid        = hs_q ? ubf_pkg::MID_FAST : ubf_pkg::MID_SLOW;
   assign nd         = nine_q ? 4'h9 : 4'h8;
   assign tx_ready   = tx_on & (tx_st_q == ubf_pkg::TX_IDLE);
   assign tx_start   = tx_ready & tx_valid;
   assign tx_bit_end = tick & (tx_ph_q == tpb_m1);
   assign tx_line    = tx_sh_q[0];
   assign tx_line_oe = tx_on;
   assign tx_busy    = (tx_st_q == ubf_pkg::TX_SEND);
   assign rx_data    = rx_data_q;
   assign rx_valid   = rx_valid_q;
   assign rx_parity_err = rx_perr_q;
   assign rx_frame_err  = rx_ferr_q;

   // format latched only while both sides idle, so no frame changes shape midway
   always_comb
   begin
      nine_d  = nine_q;
      ptype_d = ptype_q;
      pen_d   = pen_q;
      two_d   = two_q;
      hs_d    = hs_q;
      div_d   = div_q;
      if (tx_st_q == ubf_pkg::TX_IDLE && rx_st_q == ubf_pkg::RX_IDLE && !tx_start)
      begin
         nine_d  = nine_bit_select;
         ptype_d = parity_type;
         pen_d   = parity_enable;
         two_d   = two_stop_select;
         hs_d    = high_speed_select;
         div_d   = baud_divisor;
      end
   end

   // dedicated prescaler, free running; >= guards a divisor lowered mid-count
   always_comb
   begin
      tick  = (pre_q >= div_q);
      pre_d = tick ? 8'h00 : pre_q + 8'h01;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         nine_q  <= ubf_pkg::NINE_RST;
         ptype_q <= ubf_pkg::PTYPE_RST;
         pen_q   <= ubf_pkg::PEN_RST;
         two_q   <= ubf_pkg::TWO_RST;
         hs_q    <= ubf_pkg::HS_RST;
         div_q   <= ubf_pkg::DIV_RST;
         pre_q   <= ubf_pkg::DIV_RST;
      end
      else
      begin
         nine_q  <= nine_d;
         ptype_q <= ptype_d;
         pen_q   <= pen_d;
         two_q   <= two_d;
         hs_q    <= hs_d;
         div_q   <= div_d;
         pre_q   <= pre_d;
      end
   end

   // transmitter: whole frame built at once, shifted out lsb first
   always_comb
   begin
      tx_st_d    = tx_st_q;
      tx_sh_d    = tx_sh_q;
      tx_pos_d   = tx_pos_q;
      tx_len_d   = tx_len_q;
      tx_ph_d    = tx_ph_q;
      tx_first_d = tx_first_q;
      tx_par_d   = tx_par_q;
      tx_word    = {tx_ninth_bit & nine_q, tx_data};
      case (tx_st_q)
         ubf_pkg::TX_IDLE:
         begin
            tx_sh_d = ubf_pkg::FRAME_IDLE;
            if (tx_start)
            begin
               tx_par_d = (^tx_word) ^ ptype_q;
               tx_sh_d[0] = 1'b0;
               tx_sh_d[8:1] = tx_word[7:0];
               if (nine_q)
                  tx_sh_d[9] = tx_word[8];
               if (pen_q)
                  tx_sh_d[nd + 4'h1] = (^tx_word) ^ ptype_q;
               // remaining positions stay one: the stop bits
               tx_len_d   = 4'h2 + nd + {3'h0, pen_q} + {3'h0, two_q};
               tx_first_d = tx_word[0];
               tx_pos_d   = ubf_pkg::POS_RST;
               tx_ph_d    = ubf_pkg::PH_RST;
               tx_st_d    = ubf_pkg::TX_SEND;
            end
         end
         ubf_pkg::TX_SEND:
         begin
            if (tick)
               tx_ph_d = tx_bit_end ? ubf_pkg::PH_RST : tx_ph_q + 6'h01;
            if (tx_bit_end)
            begin
               tx_sh_d  = {1'b1, tx_sh_q[11:1]};
               tx_pos_d = tx_pos_q + 4'h1;
               if (tx_pos_q == tx_len_q - 4'h1)
                  tx_st_d = ubf_pkg::TX_IDLE;
            end
         end
         default:
            tx_st_d = ubf_pkg::TX_IDLE;
      endcase
      // disabling aborts at once and releases the line high
      if (!tx_on)
      begin
         tx_st_d = ubf_pkg::TX_IDLE;
         tx_sh_d = ubf_pkg::FRAME_IDLE;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_st_q    <= ubf_pkg::TX_IDLE;
         tx_sh_q    <= ubf_pkg::FRAME_IDLE;
         tx_pos_q   <= ubf_pkg::POS_RST;
         tx_len_q   <= ubf_pkg::POS_RST;
         tx_ph_q    <= ubf_pkg::PH_RST;
         tx_first_q <= 1'b0;
         tx_par_q   <= 1'b0;
      end
      else
      begin
         tx_st_q    <= tx_st_d;
         tx_sh_q    <= tx_sh_d;
         tx_pos_q   <= tx_pos_d;
         tx_len_q   <= tx_len_d;
         tx_ph_q    <= tx_ph_d;
         tx_first_q <= tx_first_d;
         tx_par_q   <= tx_par_d;
      end
   end

   // receiver: falling edge starts a frame, each bit sampled at its middle;
   // only the first stop bit is checked, a second one reads as idle
   always_comb
   begin
      logic [10:0] al;
      logic [3:0]  k;
      al         = ubf_pkg::RX_SH_RST;
      k          = nd + {3'h0, pen_q} + 4'h1;
      rx_st_d    = rx_st_q;
      rx_sh_d    = rx_sh_q;
      rx_idx_d   = rx_idx_q;
      rx_ph_d    = rx_ph_q;
      rx_prev_d  = rx_line;
      rx_data_d  = rx_data_q;
      rx_valid_d = 1'b0;
      rx_perr_d  = rx_perr_q;
      rx_ferr_d  = rx_ferr_q;
      case (rx_st_q)
         ubf_pkg::RX_IDLE:
            if (rx_prev_q && !rx_line)
            begin
               rx_st_d  = ubf_pkg::RX_BITS;
               rx_idx_d = ubf_pkg::POS_RST;
               rx_ph_d  = ubf_pkg::PH_RST;
            end
         ubf_pkg::RX_BITS:
         begin
            if (tick)
               rx_ph_d = (rx_ph_q == tpb_m1) ? ubf_pkg::PH_RST : rx_ph_q + 6'h01;
            if (tick && rx_ph_q == mid)
            begin
               rx_idx_d = rx_idx_q + 4'h1;
               if (rx_idx_q == ubf_pkg::POS_RST)
                  rx_st_d = rx_line ? ubf_pkg::RX_IDLE : rx_st_q;  // glitch, not a start bit
               else
               begin
                  rx_sh_d = {rx_line, rx_sh_q[10:1]};
                  if (rx_idx_q == k)
                     rx_st_d = ubf_pkg::RX_DONE;
               end
            end
         end
         ubf_pkg::RX_DONE:
         begin
            al = rx_sh_q >> (4'hB - k);
            rx_data_d  = nine_q ? al[8:0] : {1'b0, al[7:0]};
            rx_perr_d  = pen_q & (((^rx_data_d) ^ al[nd]) != ptype_q);
            rx_ferr_d  = !al[k - 4'h1];
            rx_valid_d = 1'b1;
            rx_st_d    = ubf_pkg::RX_IDLE;
         end
         default:
            rx_st_d = ubf_pkg::RX_IDLE;
      endcase
      if (!rx_on)
         rx_st_d = ubf_pkg::RX_IDLE;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_st_q    <= ubf_pkg::RX_IDLE;
         rx_sh_q    <= ubf_pkg::RX_SH_RST;
         rx_idx_q   <= ubf_pkg::POS_RST;
         rx_ph_q    <= ubf_pkg::PH_RST;
         rx_prev_q  <= 1'b1;
         rx_data_q  <= 9'h000;
         rx_valid_q <= 1'b0;
         rx_perr_q  <= 1'b0;
         rx_ferr_q  <= 1'b0;
      end
      else
      begin
         rx_st_q    <= rx_st_d;
         rx_sh_q    <= rx_sh_d;
         rx_idx_q   <= rx_idx_d;
         rx_ph_q    <= rx_ph_d;
         rx_prev_q  <= rx_prev_d;
         rx_data_q  <= rx_data_d;
         rx_valid_q <= rx_valid_d;
         rx_perr_q  <= rx_perr_d;
         rx_ferr_q  <= rx_ferr_d;
      end
   end
   // checks
   sequence s_tx_load;
      tx_start;
   endsequence
   sequence s_start_bit;
      !tx_line && tx_busy;
   endsequence
   a_tick_full_rate: assert property (@(posedge clk) disable iff (!reset_n)
      tick |=> tick == (div_q == 8'h00))
      else $error("tick after reload does not match divisor");
   a_prescale_wrap: assert property (@(posedge clk) disable iff (!reset_n)
      tick && pre_q == div_q |=> pre_q == 8'h00 || div_q == 8'h00)
      else $error("prescaler did not reload after tick");
   a_idle_line_high: assert property (@(posedge clk) disable iff (!reset_n)
      !tx_busy |-> tx_line)
      else $error("idle transmitter not high");
   a_start_bit_low: assert property (@(posedge clk) disable iff (!reset_n)
      s_tx_load ##1 tx_on |-> s_start_bit)
      else $error("frame did not open with start bit");
   a_lsb_first: assert property (@(posedge clk) disable iff (!reset_n)
      tx_busy && tx_pos_q == 4'h1 |-> tx_line == tx_first_q)
      else $error("first data bit is not the lsb");
   a_stop_bits_high: assert property (@(posedge clk) disable iff (!reset_n)
      tx_busy && tx_pos_q >= tx_len_q - 4'h1 - {3'h0, two_q} |-> tx_line)
      else $error("stop bit not high");
   a_parity_sent: assert property (@(posedge clk) disable iff (!reset_n)
      tx_busy && pen_q && tx_pos_q == nd + 4'h1 |-> tx_line == tx_par_q)
      else $error("parity bit wrong");
   a_reset_format: assert property (@(posedge clk)
      $rose(reset_n) |-> !nine_q && !pen_q && !two_q)
      else $error("format after reset is not 8N1");
   a_format_held: assert property (@(posedge clk) disable iff (!reset_n)
      tx_busy ##1 tx_busy |-> $stable(nine_q) && $stable(hs_q) && $stable(div_q))
      else $error("format changed during a frame");
   a_rx_one_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      rx_valid |=> !rx_valid)
      else $error("rx_valid longer than one cycle");
endmodule

// ==== tb/ubf_remote.sv ====
/*
 ubf_remote: far-end serial device; samples frames on tx_line, sends frames on rx_line.
 assumes: bench sets bit length in clocks and frame bit count; line idles high.
*/
`timescale 1ns/1ps
module ubf_remote (
   input  wire logic          clk,
   input  wire logic [15:0]   bclk,
   input  wire logic [3:0]    nb,
   input  wire logic          tx_line,
   output logic               rx_line,
   output logic [11:0]        got,
   output logic               got_valid
);
   initial
   begin
      rx_line = 1'b1;
      got = 12'hFFF;
      got_valid = 1'b0;
   end
   // mid-bit sampling, lsb first; high start sample is a glitch
   always
   begin
      @(negedge tx_line);
      got = 12'hFFF;
      repeat (bclk / 2) @(posedge clk);
      if (tx_line === 1'b0)
      begin
         for (int i = 0; i < nb; i++)
         begin
            repeat (bclk) @(posedge clk);
            got[i] = tx_line;
         end
         got_valid = 1'b1;
         @(posedge clk);
         #1 got_valid = 1'b0;
      end
   end
   // start low, then bits lsb first; line returns high after
   task automatic send(input logic [11:0] bits, input int n);
      @(posedge clk);
      #1 rx_line = 1'b0;
      repeat (bclk) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         #1 rx_line = bits[i];
         repeat (bclk) @(posedge clk);
      end
      #1 rx_line = 1'b1;
   endtask
endmodule

// ==== tb/ubf_uart_tb.sv ====
/*
 ubf_uart_tb: self-checking bench for ubf_uart against the ubf_remote far end.
 assumes: ubf_pkg and ubf_uart compiled first; 125 MHz clock.
*/
`timescale 1ns/1ps
module ubf_uart_tb;
   logic          clk, reset_n, hs, nine, ptype, pen, two, n9, uen, ten, ren, tx_valid;
   logic [7:0]    div, tx_data;
   logic          tx_ready, tx_line, tx_oe, tx_busy, rx_line, rx_valid, p_err, f_err, gv;
   logic [8:0]    rx_data;
   logic [11:0]   got;
   logic [15:0]   bclk;
   logic [3:0]    nb;
   logic [11:0]   tx_q[$];
   logic [10:0]   rx_q[$];
   // {divisor, high speed}: slow N=1, fast N=2, fast N=255
   logic [8:0]    rates[3] = '{9'h002, 9'h005, 9'h1FF};
   int            n_fail, n_checks;

   ubf_uart DUT (.clk(clk), .reset_n(reset_n), .baud_divisor(div), .high_speed_select(hs),
      .nine_bit_select(nine), .parity_type(ptype), .parity_enable(pen),
      .two_stop_select(two), .tx_ninth_bit(n9), .uart_enable(uen), .tx_enable(ten),
      .rx_enable(ren), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_line(tx_line), .tx_line_oe(tx_oe), .tx_busy(tx_busy), .rx_line(rx_line),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_err(p_err), .rx_frame_err(f_err));
   ubf_remote P (.clk(clk), .bclk(bclk), .nb(nb), .tx_line(tx_line), .rx_line(rx_line),
      .got(got), .got_valid(gv));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [11:0] rx_exp();
      return rx_q.size() ? {1'b0, rx_q.pop_front()} : 12'hFFF;
   endfunction

   // second process: each frame seen is matched to the oldest note
   always @(posedge gv)
      chk("tx_frame", got, tx_q.size() ? tx_q.pop_front() : 12'h000);
   // mid-cycle look: rx_valid stands one cycle only
   always @(negedge clk)
      if (rx_valid === 1'b1)
         chk("rx_word", {1'b0, p_err, f_err, rx_data}, rx_exp());

   // parity covers all data bits incl. ninth; stop bits preset to one
   function automatic logic [11:0] frame(input logic [8:0] d, output int n);
      logic [11:0] f;
      f = 12'hFFF;
      f[7:0] = d[7:0];
      n = nine ? 9 : 8;
      f[8] = nine ? d[8] : 1'b1;
      f[n] = pen ? ^(d & (nine ? 9'h1FF : 9'h0FF)) ^ ptype : 1'b1;
      n = n + int'(pen) + 1 + int'(two);
      return f;
   endfunction

   task automatic send_tx(input logic [8:0] d);
      chk("tx_ready", tx_ready, 12'h001);
      tx_data = d[7:0];
      n9 = d[8];
      tx_valid = 1'b1;
      @(posedge clk);
      #1 tx_valid = 1'b0;
   endtask

   // e[0] corrupts parity, e[1] the first stop bit of the rx frame
   task automatic xfer(input logic [8:0] d, input logic [1:0] e);
      logic [11:0] f;
      int n;
      int s;
      f = frame(d, n);
      s = n - 1 - int'(two);
      nb = 4'(n);
      bclk = 16'((int'(div) + 1) * (hs ? 16 : 64));
      tx_q.push_back(f);
      rx_q.push_back({e[0], e[1], nine ? d : {1'b0, d[7:0]}});
      f[s] = f[s] ^ e[1];
      f[s - 1] = f[s - 1] ^ e[0];
      // format latches only on an edge without a request, so let one pass
      @(posedge clk);
      #1;
      fork
         send_tx(d);
         P.send(f, n);
      join
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      while (!(tx_busy === 1'b0 && tx_q.size() == 0 && rx_q.size() == 0))
      begin
         @(posedge clk);
         #1;
         k++;
         if (k > 70000)
         begin
            n_fail++;
            end_sim();
         end
      end
      repeat (3) @(posedge clk);
      #1;
   endtask

   initial
   begin
      {reset_n, div, hs, nine, ptype, pen, two, n9, tx_data, tx_valid} = '0;
      {uen, ten, ren} = 3'h7;
      bclk = 16'h0010;
      nb = 4'h9;
      void'($urandom(32'h3a06));
      repeat (16) @(posedge clk);
      #1 reset_n = 1'b1;
      chk("idle_line", {tx_oe, tx_line}, 12'h003);
      for (int c = 0; c < 16; c++)
      begin
         {nine, ptype, pen, two} = 4'(c);
         xfer(9'($urandom), 2'h0);
         wait_idle();
      end
      xfer(9'($urandom), 2'h1);
      wait_idle();
      {pen, two} = 2'h0;
      xfer(9'($urandom), 2'h2);
      wait_idle();
      // changes while busy must wait for idle so both sides agree
      fork
         xfer(9'($urandom), 2'h0);
         begin
            repeat (40) @(posedge clk);
            #1 {pen, two, nine} = 3'h7;
         end
      join
      wait_idle();
      {pen, two, nine} = 3'h0;
      for (int i = 0; i < 3; i++)
      begin
         {div, hs} = rates[i];
         xfer(9'($urandom), 2'h0);
         wait_idle();
      end
      {div, hs} = 9'h001;
      send_tx(9'h000);
      repeat (4) @(posedge clk);
      #1 ten = 1'b0;
      @(posedge clk);
      #1 chk("abort", {tx_busy, tx_ready, tx_oe, tx_line}, 12'h001);
      ten = 1'b1;
      wait_idle();
      end_sim();
   end
endmodule
